/* File: hdl/jcp_pkg.sv */
// Constants, opcodes and types of the test access port programming logic
package jcp_pkg;
    localparam int IR_W = 6;
    localparam int ID_W = 32;
    localparam int STAT_W = 6;
    localparam int SIG_W = 16;
    localparam int ARR_ADDR_W = 43;
    localparam int ARR_DATA_W = 81;
    localparam int CFG_ADDR_W = 4;
    localparam int CFG_DATA_W = 41;
    localparam int N_OUT = 4;
    // Rising test-clock edges spent in Run-Test/Idle before an erase or program
    localparam logic [1:0] EXEC_EDGE = 2'h2;

    localparam logic [IR_W-1:0] IR_CAPTURE = 6'h01;
    localparam logic [IR_W-1:0] OP_EXTEST = 6'h00;
    localparam logic [IR_W-1:0] OP_ARRAY_ADDRESS_LOAD = 6'h01;
    localparam logic [IR_W-1:0] OP_ARRAY_DATA_SELECT = 6'h02;
    localparam logic [IR_W-1:0] OP_AND_PLANE_ERASE = 6'h03;
    localparam logic [IR_W-1:0] OP_ARCH_PLANE_ERASE = 6'h04;
    localparam logic [IR_W-1:0] OP_ARRAY_COLUMN_PROGRAM = 6'h05;
    localparam logic [IR_W-1:0] OP_PROTECT_FUSE_PROGRAM = 6'h06;
    localparam logic [IR_W-1:0] OP_BYPASS = 6'h07;
    localparam logic [IR_W-1:0] OP_ARRAY_COLUMN_READ = 6'h08;
    localparam logic [IR_W-1:0] OP_DISCHARGE = 6'h09;
    localparam logic [IR_W-1:0] OP_CONFIG_ADDRESS_LOAD = 6'h0a;
    localparam logic [IR_W-1:0] OP_CONFIG_DATA_SELECT = 6'h0b;
    localparam logic [IR_W-1:0] OP_CONFIG_ERASE = 6'h0c;
    localparam logic [IR_W-1:0] OP_CONFIG_COLUMN_PROGRAM = 6'h0d;
    localparam logic [IR_W-1:0] OP_CONFIG_COLUMN_READ = 6'h0e;
    localparam logic [IR_W-1:0] OP_FULL_BULK_ERASE = 6'h16;
    localparam logic [IR_W-1:0] OP_OUTPUTS_SAFE = 6'h17;
    localparam logic [IR_W-1:0] OP_PROGRAM_MODE_ENABLE = 6'h18;
    localparam logic [IR_W-1:0] OP_IDENTIFY = 6'h19;
    localparam logic [IR_W-1:0] OP_PROGRAM_MODE_DISABLE = 6'h1a;
    localparam logic [IR_W-1:0] OP_MONITOR_STATUS_SELECT = 6'h1b;
    localparam logic [IR_W-1:0] OP_SAMPLE = 6'h1c;
    localparam logic [IR_W-1:0] OP_SIGNATURE_ERASE = 6'h1d;
    localparam logic [IR_W-1:0] OP_SIGNATURE_SHIFT = 6'h1e;
    localparam logic [IR_W-1:0] OP_SIGNATURE_PROGRAM = 6'h1f;

    // Erased non-volatile content reads as zero
    localparam logic [SIG_W-1:0] SIG_ERASED = 16'h0000;
    localparam logic FUSE_ERASED = 1'b0;

    typedef enum logic [3:0] {
        TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR, TAP_PA_DR, TAP_EX2_DR,
        TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR, TAP_EX1_IR, TAP_PA_IR, TAP_EX2_IR, TAP_UPD_IR
    } jcp_tap_t;

    typedef enum logic [2:0] {
        SEL_BYPASS, SEL_ID, SEL_STATUS, SEL_SIG, SEL_AADDR, SEL_ADATA, SEL_CADDR, SEL_CDATA
    } jcp_sel_t;
endpackage

/* File: hdl/jcp_pin_sync.sv */
// Two-flop synchroniser for a group of asynchronous levels
`timescale 1ns/1ps
module jcp_pin_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= '0;
            q <= '0;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule

/* File: hdl/jcp_nvmem.sv */
// Column memory standing in for one non-volatile array
`timescale 1ns/1ps
module jcp_nvmem #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16,
    parameter int AW = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [AW-1:0] addr,
    input wire logic wr_en,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic erase_en,
    input wire logic [AW-1:0] erase_lo,
    input wire logic [AW-1:0] erase_hi,
    output logic [WIDTH-1:0] rd_data
);
    logic [WIDTH-1:0] mem_r [DEPTH];

    genvar i;
    generate
        for (i = 0; i < DEPTH; i++) begin : g_col
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    mem_r[i] <= '0;
                end else if (erase_en && AW'(i) >= erase_lo && AW'(i) <= erase_hi) begin
                    mem_r[i] <= '0;
                end else if (wr_en && addr == AW'(i)) begin
                    mem_r[i] <= wr_data;
                end
            end
        end
    endgenerate

    // Out-of-range address reads as erased
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= '0;
        end else if (int'(addr) < DEPTH) begin
            rd_data <= mem_r[addr];
        end else begin
            rd_data <= '0;
        end
    end
endmodule

/* File: hdl/jcp_tap.sv */
// Test access port: instruction decode, scan registers and array programming control
`timescale 1ns/1ps
module jcp_tap import jcp_pkg::*; #(
    parameter int ARR_COLS = ARR_ADDR_W,
    parameter int AND_COLS = 32,
    parameter int CFG_COLS = 16,
    // Arbitrary identification value, bit 0 set as the scan standard demands
    parameter logic [ID_W-1:0] ID_CODE = 32'h0c3e_a001
) (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic TCK,
    input wire logic TMS,
    input wire logic TDI,
    input wire logic [STAT_W-1:0] VOLTAGE_MONITOR_BIT,
    input wire logic [N_OUT-1:0] SEQ_OUT,
    input wire logic [N_OUT-1:0] FET_MODE,
    output logic TDO,
    output logic TDO_OE,
    output logic [N_OUT-1:0] PIN_O,
    output logic [N_OUT-1:0] PIN_OE,
    output logic SAFE_STATE,
    output logic PROG_MODE,
    output logic PROG_VOLTAGE,
    output logic PROTECT_FUSE
);
    localparam int AIW = $clog2(ARR_COLS);
    localparam int CIW = $clog2(CFG_COLS);

    logic [2:0] tap_s;
    logic tck_s;
    logic tms_s;
    logic tdi_s;
    logic tck_d_r;
    logic tck_rise;
    logic tck_fall;
    logic [STAT_W-1:0] mon_s;
    jcp_tap_t st_r;
    jcp_tap_t st_nxt;
    logic [IR_W-1:0] ir_r;
    logic [IR_W-1:0] ir_sr;
    jcp_sel_t sel;
    logic [1:0] idle_cnt_r;
    logic exec;
    logic prog_mode_r;
    logic hv_r;
    logic fuse_r;
    logic [SIG_W-1:0] sig_nv_r;
    logic bypass_r;
    logic [ID_W-1:0] id_sr;
    logic [STAT_W-1:0] stat_sr;
    logic [SIG_W-1:0] sig_sr;
    logic [ARR_ADDR_W-1:0] aaddr_sr;
    logic [ARR_DATA_W-1:0] adata_sr;
    logic [CFG_ADDR_W-1:0] caddr_sr;
    logic [CFG_DATA_W-1:0] cdata_sr;
    logic [ARR_DATA_W-1:0] arr_rd;
    logic [CFG_DATA_W-1:0] cfg_rd;
    logic arr_wr;
    logic arr_erase;
    logic [AIW-1:0] arr_lo;
    logic [AIW-1:0] arr_hi;
    logic cfg_wr;
    logic cfg_erase;
    logic safe;
    logic tdo_bit;

    jcp_pin_sync #(.W(3)) u_tap_sync (
        .clk(CLK),
        .rst_n(RESET_N),
        .d({TCK, TMS, TDI}),
        .q(tap_s)
    );

    jcp_pin_sync #(.W(STAT_W)) u_mon_sync (
        .clk(CLK),
        .rst_n(RESET_N),
        .d(VOLTAGE_MONITOR_BIT),
        .q(mon_s)
    );

    assign tck_s = tap_s[2];
    assign tms_s = tap_s[1];
    assign tdi_s = tap_s[0];

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            tck_d_r <= 1'b0;
        end else begin
            tck_d_r <= tck_s;
        end
    end

    // TCK is slow against CLK, so edges are found by sampling
    assign tck_rise = tck_s & ~tck_d_r;
    assign tck_fall = ~tck_s & tck_d_r;

    always_comb begin
        unique case (st_r)
            TAP_RESET:  st_nxt = tms_s ? TAP_RESET : TAP_IDLE;
            TAP_IDLE:   st_nxt = tms_s ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR: st_nxt = tms_s ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: st_nxt = tms_s ? TAP_EX1_DR : TAP_SH_DR;
            TAP_SH_DR:  st_nxt = tms_s ? TAP_EX1_DR : TAP_SH_DR;
            TAP_EX1_DR: st_nxt = tms_s ? TAP_UPD_DR : TAP_PA_DR;
            TAP_PA_DR:  st_nxt = tms_s ? TAP_EX2_DR : TAP_PA_DR;
            TAP_EX2_DR: st_nxt = tms_s ? TAP_UPD_DR : TAP_SH_DR;
            TAP_UPD_DR: st_nxt = tms_s ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_IR: st_nxt = tms_s ? TAP_RESET : TAP_CAP_IR;
            TAP_CAP_IR: st_nxt = tms_s ? TAP_EX1_IR : TAP_SH_IR;
            TAP_SH_IR:  st_nxt = tms_s ? TAP_EX1_IR : TAP_SH_IR;
            TAP_EX1_IR: st_nxt = tms_s ? TAP_UPD_IR : TAP_PA_IR;
            TAP_PA_IR:  st_nxt = tms_s ? TAP_EX2_IR : TAP_PA_IR;
            TAP_EX2_IR: st_nxt = tms_s ? TAP_UPD_IR : TAP_SH_IR;
            TAP_UPD_IR: st_nxt = tms_s ? TAP_SEL_DR : TAP_IDLE;
        endcase
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            st_r <= TAP_RESET;
        end else if (tck_rise) begin
            st_r <= st_nxt;
        end
    end

    // Instruction shift on rising edges, update on the falling edge inside Update-IR
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ir_sr <= IR_CAPTURE;
            ir_r <= OP_IDENTIFY;
        end else begin
            if (tck_rise && st_r == TAP_CAP_IR) begin
                ir_sr <= IR_CAPTURE;
            end else if (tck_rise && st_r == TAP_SH_IR) begin
                ir_sr <= {tdi_s, ir_sr[IR_W-1:1]};
            end
            if (st_r == TAP_RESET) begin
                ir_r <= OP_IDENTIFY;
            end else if (tck_fall && st_r == TAP_UPD_IR) begin
                ir_r <= ir_sr;
            end
        end
    end

    always_comb begin
        if (ir_r[IR_W-1]) begin
            sel = SEL_BYPASS;
        end else begin
            unique case (ir_r)
                OP_IDENTIFY:              sel = SEL_ID;
                OP_MONITOR_STATUS_SELECT: sel = SEL_STATUS;
                OP_SIGNATURE_SHIFT:       sel = SEL_SIG;
                OP_ARRAY_ADDRESS_LOAD:    sel = SEL_AADDR;
                OP_ARRAY_DATA_SELECT, OP_ARRAY_COLUMN_READ: sel = SEL_ADATA;
                OP_CONFIG_ADDRESS_LOAD:   sel = SEL_CADDR;
                OP_CONFIG_DATA_SELECT, OP_CONFIG_COLUMN_READ: sel = SEL_CDATA;
                default:                  sel = SEL_BYPASS;
            endcase
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            idle_cnt_r <= 2'h0;
        end else if (tck_rise) begin
            if (st_r != TAP_IDLE) begin
                idle_cnt_r <= 2'h0;
            end else if (idle_cnt_r != EXEC_EDGE) begin
                idle_cnt_r <= idle_cnt_r + 2'h1;
            end
        end
    end

    // Only the second idle edge fires; staying in idle longer does not repeat it
    assign exec = tck_rise && st_r == TAP_IDLE && idle_cnt_r == EXEC_EDGE - 2'h1 && prog_mode_r;

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            prog_mode_r <= 1'b0;
        end else if (st_r == TAP_RESET) begin
            prog_mode_r <= 1'b0;
        end else if (tck_fall && st_r == TAP_UPD_IR) begin
            if (ir_sr == OP_PROGRAM_MODE_ENABLE) begin
                prog_mode_r <= 1'b1;
            end else if (ir_sr == OP_PROGRAM_MODE_DISABLE) begin
                prog_mode_r <= 1'b0;
            end
        end
    end

    // Programming voltage rises with any erase or program and stays until discharged
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            hv_r <= 1'b0;
        end else if (exec && (arr_wr || arr_erase || cfg_wr || cfg_erase || ir_r == OP_PROTECT_FUSE_PROGRAM
                              || ir_r == OP_SIGNATURE_ERASE || ir_r == OP_SIGNATURE_PROGRAM)) begin
            hv_r <= 1'b1;
        end else if (tck_fall && st_r == TAP_UPD_IR && ir_sr == OP_DISCHARGE) begin
            hv_r <= 1'b0;
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            fuse_r <= FUSE_ERASED;
            sig_nv_r <= SIG_ERASED;
        end else if (exec) begin
            unique case (ir_r)
                OP_PROTECT_FUSE_PROGRAM: fuse_r <= 1'b1;
                OP_SIGNATURE_ERASE:      sig_nv_r <= SIG_ERASED;
                OP_SIGNATURE_PROGRAM:    sig_nv_r <= sig_sr;
                OP_FULL_BULK_ERASE: begin
                    fuse_r <= FUSE_ERASED;
                    sig_nv_r <= SIG_ERASED;
                end
                default: ;
            endcase
        end
    end

    assign arr_wr = exec && ir_r == OP_ARRAY_COLUMN_PROGRAM;
    assign arr_erase = exec && (ir_r == OP_AND_PLANE_ERASE || ir_r == OP_ARCH_PLANE_ERASE
                                || ir_r == OP_FULL_BULK_ERASE);
    assign arr_lo = (ir_r == OP_ARCH_PLANE_ERASE) ? AIW'(AND_COLS) : '0;
    assign arr_hi = (ir_r == OP_AND_PLANE_ERASE) ? AIW'(AND_COLS - 1) : AIW'(ARR_COLS - 1);
    assign cfg_wr = exec && ir_r == OP_CONFIG_COLUMN_PROGRAM;
    assign cfg_erase = exec && (ir_r == OP_CONFIG_ERASE || ir_r == OP_FULL_BULK_ERASE);

    jcp_nvmem #(.WIDTH(ARR_DATA_W), .DEPTH(ARR_COLS), .AW(AIW)) u_arr_mem (
        .clk(CLK),
        .rst_n(RESET_N),
        .addr(aaddr_sr[AIW-1:0]),
        .wr_en(arr_wr),
        .wr_data(adata_sr),
        .erase_en(arr_erase),
        .erase_lo(arr_lo),
        .erase_hi(arr_hi),
        .rd_data(arr_rd)
    );

    jcp_nvmem #(.WIDTH(CFG_DATA_W), .DEPTH(CFG_COLS), .AW(CIW)) u_cfg_mem (
        .clk(CLK),
        .rst_n(RESET_N),
        .addr(caddr_sr[CIW-1:0]),
        .wr_en(cfg_wr),
        .wr_data(cdata_sr),
        .erase_en(cfg_erase),
        .erase_lo('0),
        .erase_hi(CIW'(CFG_COLS - 1)),
        .rd_data(cfg_rd)
    );

    // Data registers: capture, then shift toward bit 0 which faces TDO
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            bypass_r <= 1'b0;
            id_sr <= '0;
            stat_sr <= '0;
            sig_sr <= '0;
            aaddr_sr <= '0;
            adata_sr <= '0;
            caddr_sr <= '0;
            cdata_sr <= '0;
        end else if (tck_rise && st_r == TAP_CAP_DR) begin
            unique case (sel)
                SEL_BYPASS: bypass_r <= 1'b0;
                SEL_ID:     id_sr <= ID_CODE;
                SEL_STATUS: stat_sr <= {<<{mon_s}};
                SEL_SIG:    sig_sr <= fuse_r ? '0 : sig_nv_r;
                SEL_ADATA: begin
                    if (ir_r == OP_ARRAY_COLUMN_READ) begin
                        adata_sr <= fuse_r ? '0 : arr_rd;
                    end
                end
                SEL_CDATA: begin
                    if (ir_r == OP_CONFIG_COLUMN_READ) begin
                        cdata_sr <= fuse_r ? '0 : cfg_rd;
                    end
                end
                default: ;
            endcase
        end else if (tck_rise && st_r == TAP_SH_DR) begin
            unique case (sel)
                SEL_BYPASS: bypass_r <= tdi_s;
                SEL_ID:     id_sr <= {tdi_s, id_sr[ID_W-1:1]};
                SEL_STATUS: stat_sr <= {tdi_s, stat_sr[STAT_W-1:1]};
                SEL_SIG:    sig_sr <= {tdi_s, sig_sr[SIG_W-1:1]};
                SEL_AADDR:  aaddr_sr <= {tdi_s, aaddr_sr[ARR_ADDR_W-1:1]};
                SEL_ADATA:  adata_sr <= {tdi_s, adata_sr[ARR_DATA_W-1:1]};
                SEL_CADDR:  caddr_sr <= {tdi_s, caddr_sr[CFG_ADDR_W-1:1]};
                SEL_CDATA:  cdata_sr <= {tdi_s, cdata_sr[CFG_DATA_W-1:1]};
            endcase
        end
    end

    always_comb begin
        unique case (sel)
            SEL_BYPASS: tdo_bit = bypass_r;
            SEL_ID:     tdo_bit = id_sr[0];
            SEL_STATUS: tdo_bit = stat_sr[0];
            SEL_SIG:    tdo_bit = sig_sr[0];
            SEL_AADDR:  tdo_bit = aaddr_sr[0];
            SEL_ADATA:  tdo_bit = adata_sr[0];
            SEL_CADDR:  tdo_bit = caddr_sr[0];
            SEL_CDATA:  tdo_bit = cdata_sr[0];
        endcase
        if (st_r == TAP_SH_IR) begin
            tdo_bit = ir_sr[0];
        end
    end

    // TDO moves on the falling edge so the programmer samples a settled bit
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            TDO <= 1'b0;
            TDO_OE <= 1'b0;
        end else if (tck_fall) begin
            TDO <= tdo_bit;
            TDO_OE <= st_r == TAP_SH_DR || st_r == TAP_SH_IR;
        end
    end

    // Every array, config and erase opcode, and program-mode enable but not disable, forces the safe state while current
    always_comb begin
        unique case (ir_r)
            OP_ARRAY_ADDRESS_LOAD, OP_ARRAY_DATA_SELECT, OP_AND_PLANE_ERASE, OP_ARCH_PLANE_ERASE,
            OP_ARRAY_COLUMN_PROGRAM, OP_PROTECT_FUSE_PROGRAM, OP_ARRAY_COLUMN_READ, OP_DISCHARGE,
            OP_CONFIG_ADDRESS_LOAD, OP_CONFIG_DATA_SELECT, OP_CONFIG_ERASE, OP_CONFIG_COLUMN_PROGRAM,
            OP_CONFIG_COLUMN_READ, OP_FULL_BULK_ERASE, OP_OUTPUTS_SAFE, OP_PROGRAM_MODE_ENABLE,
            OP_SIGNATURE_ERASE, OP_SIGNATURE_PROGRAM: safe = 1'b1;
            default: safe = prog_mode_r;
        endcase
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            SAFE_STATE <= 1'b0;
            PROG_MODE <= 1'b0;
            PROG_VOLTAGE <= 1'b0;
            PROTECT_FUSE <= FUSE_ERASED;
        end else begin
            SAFE_STATE <= safe;
            PROG_MODE <= prog_mode_r;
            PROG_VOLTAGE <= hv_r;
            PROTECT_FUSE <= fuse_r;
        end
    end

    genvar p;
    generate
        for (p = 0; p < N_OUT; p++) begin : g_pin
            always_ff @(posedge CLK or negedge RESET_N) begin
                if (!RESET_N) begin
                    PIN_O[p] <= 1'b0;
                    PIN_OE[p] <= 1'b0;
                end else if (FET_MODE[p]) begin
                    PIN_O[p] <= safe ? 1'b0 : SEQ_OUT[p];
                    PIN_OE[p] <= 1'b1;
                end else begin
                    // Open drain pulls low for a zero, released when safe
                    PIN_O[p] <= 1'b0;
                    PIN_OE[p] <= ~safe & ~SEQ_OUT[p];
                end
            end
        end
    endgenerate
endmodule

/* File: tb/jcp_tap_monitor.sv */
// Concurrent checks on the programming port outputs
`timescale 1ns/1ps
module jcp_tap_monitor import jcp_pkg::*; (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic TCK,
    input wire logic [N_OUT-1:0] SEQ_OUT,
    input wire logic [N_OUT-1:0] FET_MODE,
    input wire logic TDO,
    input wire logic TDO_OE,
    input wire logic [N_OUT-1:0] PIN_O,
    input wire logic [N_OUT-1:0] PIN_OE,
    input wire logic SAFE_STATE,
    input wire logic PROG_MODE,
    input wire logic PROG_VOLTAGE,
    input wire logic PROTECT_FUSE
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    // Three quiet cycles so a registered pin stage has settled
    sequence s_held(s);
        (SAFE_STATE == s && $stable(FET_MODE) && $stable(SEQ_OUT))[*3];
    endsequence
    a_safe_pins_off: assert property (s_held(1'b1) |-> PIN_OE == FET_MODE && PIN_O == '0)
        else $error("pins not safe");
    a_normal_pins_on: assert property (s_held(1'b0) |->
        PIN_OE == (FET_MODE | ~SEQ_OUT) && PIN_O == (FET_MODE & SEQ_OUT))
        else $error("pins not normal");
    a_prog_forces_safe: assert property (PROG_MODE && $past(PROG_MODE) |-> SAFE_STATE)
        else $error("program mode without safe state");
    a_mode_exit_safe: assert property ($fell(PROG_MODE) |-> ##[0:2] !SAFE_STATE)
        else $error("safe state kept after program mode");
    a_fuse_set_prog: assert property ($rose(PROTECT_FUSE) |-> PROG_MODE)
        else $error("fuse set outside program mode");
    a_fuse_clear_prog: assert property ($fell(PROTECT_FUSE) |-> PROG_MODE)
        else $error("fuse cleared outside program mode");
    a_voltage_needs_prog: assert property ($rose(PROG_VOLTAGE) |-> PROG_MODE && SAFE_STATE)
        else $error("array cycle outside program mode");
    a_tdo_on_fall: assert property ($changed(TDO) |-> !TCK && !$past(TCK, 2))
        else $error("serial out moved while clock high");
    a_oe_on_fall: assert property ($changed(TDO_OE) |-> !TCK && !$past(TCK, 2))
        else $error("serial enable moved while clock high");
endmodule
bind jcp_tap jcp_tap_monitor u_mon (.CLK(CLK), .RESET_N(RESET_N), .TCK(TCK), .SEQ_OUT(SEQ_OUT), .FET_MODE(FET_MODE),
    .TDO(TDO), .TDO_OE(TDO_OE), .PIN_O(PIN_O), .PIN_OE(PIN_OE), .SAFE_STATE(SAFE_STATE), .PROG_MODE(PROG_MODE),
    .PROG_VOLTAGE(PROG_VOLTAGE), .PROTECT_FUSE(PROTECT_FUSE));

/* File: tb/jcp_prog_model.sv */
// Programmer model driving the four-wire test port
`timescale 1ns/1ps
module jcp_prog_model (
    input wire logic clk,
    input wire logic tdo,
    input wire logic tdo_oe,
    output logic tck,
    output logic tms,
    output logic tdi
);
    logic t;
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end
    // Clock rests low between frames; TDO read just before each rise
    task automatic step(input logic m, input logic d);
        tms = m;
        tdi = d;
        repeat (4) @(negedge clk);
        // Released line floats high on its pull-up
        t = tdo_oe ? tdo : 1'b1;
        tck = 1'b1;
        repeat (4) @(negedge clk);
        tck = 1'b0;
    endtask
    task automatic idle(input int n);
        repeat (n) step(1'b0, 1'($urandom));
    endtask
    task automatic tlr();
        repeat (5) step(1'b1, 1'($urandom));
        step(1'b0, 1'($urandom));
    endtask
    // From Idle through a full IR or DR scan, back to Idle
    task automatic scan(input logic ir, input int n, input logic [127:0] din, output logic [127:0] dout);
        dout = '0;
        step(1'b1, 1'($urandom));
        if (ir)
            step(1'b1, 1'($urandom));
        idle(2);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i]);
            dout[i] = t;
        end
        step(1'b1, 1'($urandom));
        step(1'b0, 1'($urandom));
    endtask
endmodule

/* File: tb/jtag_config_program_control_tb_top.sv */
// Self-checking bench of the test port programming logic
`timescale 1ns/1ps
`define CHK(o, e) begin exp_q.push_back(128'(e)); obs = 128'(o); ->got; #1; end
module jtag_config_program_control_tb_top import jcp_pkg::*;;
    localparam logic [ID_W-1:0] ID_V = 32'h5a5a_0f01; // Arbitrary value, bit 0 set
    logic clk;
    logic reset_n;
    logic tck, tms, tdi, tdo, tdo_oe, safe, prog, volt, fuse;
    logic [STAT_W-1:0] mon, sx;
    logic [N_OUT-1:0] seq_out, fet_mode, pin_o, pin_oe;
    logic [127:0] exp_q[$];
    logic [127:0] obs, r, e, d, mask;
    logic [IR_W-1:0] byp[4];
    logic [IR_W-1:0] tbl[2][5] = '{'{OP_ARRAY_ADDRESS_LOAD, OP_ARRAY_DATA_SELECT, OP_AND_PLANE_ERASE,
        OP_ARRAY_COLUMN_PROGRAM, OP_ARRAY_COLUMN_READ}, '{OP_CONFIG_ADDRESS_LOAD, OP_CONFIG_DATA_SELECT,
        OP_CONFIG_ERASE, OP_CONFIG_COLUMN_PROGRAM, OP_CONFIG_COLUMN_READ}};
    int aw[2] = '{ARR_ADDR_W, CFG_ADDR_W};
    int dw[2] = '{ARR_DATA_W, CFG_DATA_W};
    int num_errors = 0, n_compared = 0, cycles = 0;
    event got;
    always #50 clk = ~clk;
    jcp_tap #(.ID_CODE(ID_V)) dut (.CLK(clk), .RESET_N(reset_n), .TCK(tck), .TMS(tms), .TDI(tdi),
        .VOLTAGE_MONITOR_BIT(mon), .SEQ_OUT(seq_out), .FET_MODE(fet_mode), .TDO(tdo), .TDO_OE(tdo_oe),
        .PIN_O(pin_o), .PIN_OE(pin_oe), .SAFE_STATE(safe), .PROG_MODE(prog), .PROG_VOLTAGE(volt),
        .PROTECT_FUSE(fuse));
    jcp_prog_model u_prog (.clk(clk), .tdo(tdo), .tdo_oe(tdo_oe), .tck(tck), .tms(tms), .tdi(tdi));
    always @(got) begin
        e = exp_q.pop_front();
        n_compared++;
        if (e !== obs) begin
            num_errors++;
            $display("wrong value at %0t: expected %0h, got %0h", $time, e, obs);
        end
    end
    task automatic print_verdict();
        $display("compared %0d, errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Whole run needs about 10000 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            num_errors++;
            print_verdict();
        end
    end
    task automatic ir(input logic [IR_W-1:0] op);
        u_prog.scan(1'b1, IR_W, 128'(op), r);
        `CHK(r[IR_W-1:0], IR_CAPTURE)
    endtask
    task automatic sig_read();
        ir(OP_SIGNATURE_SHIFT);
        u_prog.scan(1'b0, SIG_W, d, r);
    endtask
    initial begin
        clk = 1'b0;
        reset_n = 1'b0;
        mon = '0;
        seq_out = '0;
        fet_mode = '0;
        void'($urandom(82357));
        repeat (8) @(negedge clk);
        reset_n = 1'b1;
        repeat (4) @(negedge clk);
        fet_mode = 4'($urandom);
        seq_out = 4'($urandom);
        mon = 6'($urandom);
        u_prog.idle(1);
        u_prog.scan(1'b0, ID_W, 128'($urandom), r);
        `CHK(r[ID_W-1:0], ID_V)
        ir(OP_MONITOR_STATUS_SELECT);
        u_prog.scan(1'b0, STAT_W, '0, r);
        sx = {<<{mon}};
        `CHK(r[STAT_W-1:0], sx)
        byp = '{OP_EXTEST, OP_SAMPLE, OP_BYPASS, 6'h20 | 6'($urandom)};
        foreach (byp[k]) begin
            ir(byp[k]);
            d = 128'($urandom);
            u_prog.scan(1'b0, 8, d, r);
            `CHK(r[7:0], {d[6:0], 1'b0})
        end
        ir(OP_OUTPUTS_SAFE);
        `CHK({safe, tdo_oe, pin_oe, pin_o}, {2'b10, fet_mode, 4'h0})
        d = 128'($urandom);
        sig_read();
        ir(OP_SIGNATURE_PROGRAM);
        u_prog.idle(3);
        sig_read();
        `CHK({volt, r[SIG_W-1:0]}, {1'b0, SIG_ERASED})
        ir(OP_PROGRAM_MODE_ENABLE);
        `CHK({prog, safe}, 2'h3)
        ir(OP_SIGNATURE_ERASE);
        u_prog.idle(2);
        // The erase raised the programming voltage; drop it before the next cycle
        ir(OP_DISCHARGE);
        sig_read();
        ir(OP_SIGNATURE_PROGRAM);
        u_prog.idle(1);
        `CHK(volt, 1'b0)
        u_prog.idle(1);
        `CHK({volt, safe}, 2'h3)
        ir(OP_DISCHARGE);
        `CHK({volt, safe}, 2'h1)
        sig_read();
        `CHK(r[SIG_W-1:0], d[SIG_W-1:0])
        for (int k = 0; k < 2; k++) begin
            ir(tbl[k][2]);
            u_prog.idle(2);
            if (k == 0) begin
                ir(OP_ARCH_PLANE_ERASE);
                u_prog.idle(2);
            end
            ir(tbl[k][0]);
            u_prog.scan(1'b0, aw[k], 128'(3 + 2 * k), r);
            ir(tbl[k][1]);
            d = {$urandom, $urandom, $urandom, $urandom};
            u_prog.scan(1'b0, dw[k], d, r);
            ir(tbl[k][3]);
            u_prog.idle(2);
            ir(OP_DISCHARGE);
            ir(tbl[k][4]);
            u_prog.scan(1'b0, dw[k], '0, r);
            mask = (128'h1 << dw[k]) - 128'h1;
            `CHK({safe, r & mask}, {1'b1, d & mask})
            ir(tbl[k][2]);
            u_prog.idle(2);
            ir(tbl[k][4]);
            u_prog.scan(1'b0, dw[k], '0, r);
            `CHK(r & mask, 128'h0)
        end
        ir(OP_PROTECT_FUSE_PROGRAM);
        u_prog.idle(2);
        sig_read();
        `CHK({fuse, r[SIG_W-1:0]}, {1'b1, SIG_ERASED})
        ir(OP_FULL_BULK_ERASE);
        u_prog.idle(2);
        ir(OP_DISCHARGE);
        sig_read();
        `CHK({fuse, r[SIG_W-1:0]}, {FUSE_ERASED, SIG_ERASED})
        seq_out = 4'($urandom);
        ir(OP_PROGRAM_MODE_DISABLE);
        `CHK({prog, safe, pin_oe, pin_o}, {2'b00, fet_mode | ~seq_out, fet_mode & seq_out})
        ir(OP_PROGRAM_MODE_ENABLE);
        u_prog.tlr();
        u_prog.scan(1'b0, ID_W, '0, r);
        `CHK({prog, r[ID_W-1:0]}, {1'b0, ID_V})
        print_verdict();
    end
endmodule
